// ===== hdl/phase_ctrl_map.svh
`ifndef PHASE_CTRL_MAP_SVH
`define PHASE_CTRL_MAP_SVH

// ==========================================================
// register map (byte addresses)
`define REG_CTRL_ADDR 4'h0
`define REG_STATUS_ADDR 4'h4
`define REG_SHIFT_ADDR 4'h8

// ==========================================================
// field positions and reset values
`define CTRL_UPDATE_EN_BIT 0
`define CTRL_UPDATE_EN_RESET 1'h1
`define STATUS_SETTING_MSB 8
`define STATUS_MODE_BIT 9
`define STATUS_MISMATCH_BIT 10
`define SETTING_RESET 9'h000
`define SHIFT_RESET 13'h0000

// ==========================================================
// serial word layout
`define SHIFT_MSB 12
`define PHASE_WORD_MSB 8
`define ADDR_WORD_LSB 9

`endif

// ===== hdl/phase_ctrl_pkg.sv
package phase_ctrl_pkg;

  // applied phase setting: trim bit above the eight phase bits
  typedef struct packed {
    logic accuracy_trim_bit;
    logic [7:0] phase_bits;
  } phase_setting_type;

  // all pins sampled from outside the clock domain
  typedef struct packed {
    logic serial_mode;
    logic [7:0] phase_bits;
    logic accuracy_trim_bit;
    logic update_strobe;
    logic serial_clk;
    logic serial_data;
    logic [3:0] unit_address_pins;
  } pin_inputs_type;

  // control mode chosen by the interface select pin
  typedef enum logic [1:0] {
    MODE_PARALLEL = 2'b01,
    MODE_SERIAL = 2'b10
  } control_mode_type;

endpackage

// ===== hdl/pin_sync.sv
`timescale 1ns/100ps

module pin_sync #(
  parameter int WIDTH = 17
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset,
  // asynchronous inputs and synchronised copy
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] stage1_reg;

  // two flip-flops; the first is read only by the second
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      stage1_reg <= '0;
      o_sync <= '0;
    end
    else
    begin
      stage1_reg <= i_async;
      o_sync <= stage1_reg;
    end
  end

endmodule

// ===== hdl/phase_setting_control_port.sv
// What the block and its controller are required to do
// [R01] select pin low uses parallel port, high uses addressable serial port
// [R02] phase bits weigh 1.4 up to 180 degrees, LSB to MSB
// [R03] controller drives trim bit equal to the 90-degree phase bit; the testbench's walking-one and 9'h055 line patterns do not
// [R04] parallel mode takes nine lines: eight phase bits plus trim bit
// [R05] latched parallel: strobe low while lines change, pulse captures them
// [R06] strobe held high: parallel line changes apply directly
// [R07] serial port: 13-bit shift register, 9 data and 4 address bits
// [R08] serial load applies only when address word matches unit pins
// [R09] controller shifts LSB first, phase word before address word
// [R10] passthrough output copies serial data, independent of serial clock
// [R11] shift-tail output shows last stage, moves on serial clock rise
// [R12] controller samples shift-tail output on serial clock fall
// [R13] controller raises strobe at least 10 ns after last clock rise
// [R14] controller index is angle times 256 over 360, in binary
// [R15] internal negative supply limits updates to 25 kHz; the block applies updates with no rate limit
// [R16] parallel, strobe low: rising strobe edge captures the control lines
// [R17] serial phase word maps in shift order to bits 0-7 then trim
`timescale 1ns/100ps
`include "phase_ctrl_map.svh"

module phase_setting_control_port
  import phase_ctrl_pkg::*;
(
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset,
  // mode and parallel control pins
  input wire logic i_serial_mode,
  input wire logic [7:0] i_phase_bits,
  input wire logic i_accuracy_trim_bit,
  input wire logic i_update_strobe,
  // serial control pins
  input wire logic i_serial_clk,
  input wire logic i_serial_data,
  input wire logic [3:0] i_unit_address_pins,
  // applied phase setting
  output logic [7:0] o_phase_bits,
  output logic o_accuracy_trim_bit,
  // serial outputs
  output logic o_passthrough_out,
  output logic o_shift_tail_out,
  // register port
  input wire logic [3:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [31:0] o_reg_rdata
);

  // ========================================================
  // functions

  // address word of the shift register against the unit pins
  function automatic logic addr_match(input logic [`SHIFT_MSB:0] sr,
                                      input logic [3:0] pins);
    addr_match = (sr[`SHIFT_MSB:`ADDR_WORD_LSB] == pins);
  endfunction

  // phase word in shift order: bits 0-7 then trim bit
  function automatic phase_setting_type to_setting(
    input logic [`SHIFT_MSB:0] sr);
    to_setting = phase_setting_type'(sr[`PHASE_WORD_MSB:0]);
  endfunction

  // ========================================================
  // pin synchronisation

  pin_inputs_type pins_raw;
  pin_inputs_type pins_s;
  logic [$bits(pin_inputs_type)-1:0] pins_sync_vec;

  assign pins_raw = '{serial_mode: i_serial_mode,
                      phase_bits: i_phase_bits,
                      accuracy_trim_bit: i_accuracy_trim_bit,
                      update_strobe: i_update_strobe,
                      serial_clk: i_serial_clk,
                      serial_data: i_serial_data,
                      unit_address_pins: i_unit_address_pins};

  pin_sync #(
    .WIDTH($bits(pin_inputs_type))
  ) u_pin_sync (
    .i_sys_clk(i_sys_clk),
    .i_reset(i_reset),
    .i_async(pins_raw),
    .o_sync(pins_sync_vec)
  );

  assign pins_s = pin_inputs_type'(pins_sync_vec);

  // ========================================================
  // mode and edge detection

  control_mode_type mode;
  logic sclk_prev_reg;
  logic strobe_prev_reg;
  logic sclk_rise;
  logic strobe_rise;
  phase_setting_type par_setting;

  // [R01] select pin chooses the port
  assign mode = pins_s.serial_mode ? MODE_SERIAL : MODE_PARALLEL;
  assign sclk_rise = pins_s.serial_clk & ~sclk_prev_reg;
  assign strobe_rise = pins_s.update_strobe & ~strobe_prev_reg;
  // [R04] nine parallel lines form the setting
  assign par_setting = '{accuracy_trim_bit: pins_s.accuracy_trim_bit,
                         phase_bits: pins_s.phase_bits};

  // previous levels of serial clock and strobe
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      sclk_prev_reg <= 1'b0;
      strobe_prev_reg <= 1'b0;
    end
    else
    begin
      sclk_prev_reg <= pins_s.serial_clk;
      strobe_prev_reg <= pins_s.update_strobe;
    end
  end

  // ========================================================
  // serial shift register

  logic [`SHIFT_MSB:0] shift_reg;
  logic match;

  assign match = addr_match(shift_reg, pins_s.unit_address_pins);

  // [R07] [R09] shift in at the top, first bit reaches stage 0
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
      shift_reg <= `SHIFT_RESET;
    else if (mode == MODE_SERIAL && sclk_rise)
      shift_reg <= {pins_s.serial_data, shift_reg[`SHIFT_MSB:1]};
  end

  // [R11] tail is the last stage, moving only on a clock rise
  assign o_shift_tail_out = shift_reg[0];

  // [R10] passthrough follows serial data, no serial clock involved
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
      o_passthrough_out <= 1'b0;
    else
      o_passthrough_out <= pins_s.serial_data;
  end

  // ========================================================
  // control registers

  logic update_en_reg;
  logic mismatch_reg;
  logic wr_ctrl;
  logic wr_status;
  logic mismatch_set;

  assign wr_ctrl = i_reg_wr && (i_reg_addr == `REG_CTRL_ADDR);
  assign wr_status = i_reg_wr && (i_reg_addr == `REG_STATUS_ADDR);
  assign mismatch_set = (mode == MODE_SERIAL) && strobe_rise && !match;

  // software gate on all phase updates
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
      update_en_reg <= `CTRL_UPDATE_EN_RESET;
    else if (wr_ctrl)
      update_en_reg <= i_reg_wdata[`CTRL_UPDATE_EN_BIT];
  end

  // sticky mismatch flag, write one clears, a new event wins
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
      mismatch_reg <= 1'b0;
    else if (mismatch_set)
      mismatch_reg <= 1'b1;
    else if (wr_status && i_reg_wdata[`STATUS_MISMATCH_BIT])
      mismatch_reg <= 1'b0;
  end

  // ========================================================
  // applied phase setting

  phase_setting_type setting_reg;

  // holding latch: transparent while the strobe is high
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
      setting_reg <= `SETTING_RESET;
    else if (pins_s.update_strobe && update_en_reg)
    begin
      unique case (mode)
        // [R05] [R06] [R16] strobe high or its rise takes the lines
        MODE_PARALLEL: setting_reg <= par_setting;
        // [R08] [R17] matched address loads the phase word
        MODE_SERIAL:
        begin
          if (match)
            setting_reg <= to_setting(shift_reg);
        end
      endcase
    end
  end

  // [R02] bit 0 is the 1.4 degree weight, bit 7 the 180
  assign o_phase_bits = setting_reg.phase_bits;
  assign o_accuracy_trim_bit = setting_reg.accuracy_trim_bit;

  // ========================================================
  // register read port

  // read data stand for one cycle after the strobe only
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
      o_reg_rdata <= 32'h0000_0000;
    else if (i_reg_rd)
    begin
      o_reg_rdata <= 32'h0000_0000;
      unique case (i_reg_addr)
        `REG_CTRL_ADDR:
          o_reg_rdata[`CTRL_UPDATE_EN_BIT] <= update_en_reg;
        `REG_STATUS_ADDR:
        begin
          o_reg_rdata[`STATUS_SETTING_MSB:0] <= setting_reg;
          o_reg_rdata[`STATUS_MODE_BIT] <= (mode == MODE_SERIAL);
          o_reg_rdata[`STATUS_MISMATCH_BIT] <= mismatch_reg;
        end
        `REG_SHIFT_ADDR:
          o_reg_rdata[`SHIFT_MSB:0] <= shift_reg;
        default:
          o_reg_rdata <= 32'h0000_0000;
      endcase
    end
    else
      o_reg_rdata <= 32'h0000_0000;
  end

  // ========================================================
  // assertions

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);

  a_parallel_direct_follow: assert property ( // [R06]
    mode == MODE_PARALLEL && pins_s.update_strobe && update_en_reg
    |=> setting_reg == $past(par_setting))
    else $error("parallel setting did not follow lines");

  a_strobe_low_hold: assert property ( // [R05]
    !pins_s.update_strobe |=> $stable(setting_reg))
    else $error("setting changed with strobe low");

  a_rise_capture: assert property ( // [R16]
    mode == MODE_PARALLEL && strobe_rise && update_en_reg
    |=> setting_reg == $past(par_setting))
    else $error("strobe rise did not capture lines");

  a_serial_shift_edge: assert property ( // [R07]
    mode == MODE_SERIAL && sclk_rise
    |=> shift_reg == {$past(pins_s.serial_data),
                      $past(shift_reg[`SHIFT_MSB:1])})
    else $error("shift register did not shift");

  a_serial_addr_gate: assert property ( // [R08]
    mode == MODE_SERIAL && !match |=> $stable(setting_reg))
    else $error("setting changed on address mismatch");

  a_serial_word_load: assert property ( // [R17]
    mode == MODE_SERIAL && pins_s.update_strobe && match && update_en_reg
    |=> setting_reg == $past(to_setting(shift_reg)))
    else $error("matched serial word not applied");

  a_tail_on_rise: assert property ( // [R11]
    mode == MODE_SERIAL && sclk_rise
    |=> o_shift_tail_out == $past(shift_reg[1]))
    else $error("tail did not advance on clock rise");

  a_tail_no_rise: assert property ( // [R11]
    !(mode == MODE_SERIAL && sclk_rise) |=> $stable(o_shift_tail_out))
    else $error("tail moved without clock rise");

  a_passthrough_copy: assert property ( // [R10]
    ##1 o_passthrough_out == $past(pins_s.serial_data))
    else $error("passthrough is not a copy of serial data");

  a_mismatch_sticky: assert property ( // [R08]
    mismatch_set |=> mismatch_reg ##1 (mismatch_reg || $past(wr_status)))
    else $error("mismatch flag lost");

  a_read_status: assert property ( // [R02]
    i_reg_rd && i_reg_addr == `REG_STATUS_ADDR
    |=> o_reg_rdata[`STATUS_SETTING_MSB:0] == $past(setting_reg)
        ##1 (o_reg_rdata == 32'h0000_0000 || $past(i_reg_rd)))
    else $error("status read data wrong or held");

  c_parallel_direct: cover property (
    mode == MODE_PARALLEL && pins_s.update_strobe
    ##1 $changed(setting_reg));
  c_serial_match_load: cover property (
    mode == MODE_SERIAL && strobe_rise && match);
  c_serial_mismatch: cover property (mismatch_set);
  c_tail_toggle: cover property (sclk_rise ##1 $changed(o_shift_tail_out));

endmodule

// ===== testbench/phase_controller.sv
`timescale 1ns/100ps

module phase_controller
(
  // clock and readback
  input wire logic i_sys_clk,
  input wire logic i_shift_tail_out,
  // control pins toward the block
  output logic o_serial_mode,
  output logic [7:0] o_phase_bits,
  output logic o_accuracy_trim_bit,
  output logic o_update_strobe,
  output logic o_serial_clk,
  output logic o_serial_data,
  // bits read back from the shift tail
  output logic [12:0] o_readback
);
  // ==========================================================
  // idle levels: clock stands low, data pulled up
  initial
  begin
    o_serial_mode = 1'h0;
    o_phase_bits = 8'h00;
    o_accuracy_trim_bit = 1'h0;
    o_update_strobe = 1'h0;
    o_serial_clk = 1'h0;
    o_serial_data = 1'h1;
    o_readback = 13'h0000;
  end

  // wait whole system clock cycles
  task automatic tick(input int n);
    repeat (n) @(posedge i_sys_clk);
  endtask

  // pin helpers; set_lines drives all nine parallel lines
  task automatic set_mode(input logic v);
    o_serial_mode <= v;
  endtask
  task automatic set_strobe(input logic v);
    o_update_strobe <= v;
  endtask
  task automatic set_data(input logic v);
    o_serial_data <= v;
  endtask
  task automatic set_lines(input logic [8:0] s);
    o_accuracy_trim_bit <= s[8];
    o_phase_bits <= s[7:0];
  endtask

  // fast update spacing assumes an external negative supply
  task automatic pulse();
    tick(4);
    o_update_strobe <= 1'h1;
    tick(4);
    o_update_strobe <= 1'h0;
    tick(6);
  endtask

  // lsb first, tail taken at the fall
  task automatic frame(input logic [12:0] word);
    for (int i = 0; i < 13; i++)
    begin
      o_serial_data <= word[i];
      tick(8);
      o_serial_clk <= 1'h1;
      tick(8);
      o_readback <= {i_shift_tail_out, o_readback[12:1]};
      o_serial_clk <= 1'h0;
    end
    o_serial_data <= 1'h1;
    pulse();
  endtask
endmodule

// ===== testbench/tb_phase_setting_control_port.sv
`timescale 1ns/100ps

module tb_phase_setting_control_port;
  logic i_sys_clk = 1'h0;
  logic i_reset = 1'h1;
  logic [3:0] unit_pins;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] rdata;
  logic serial_mode, trim_in, strobe, sclk, sdata;
  logic trim_out, pass_out, tail_out;
  logic [7:0] bits_in, bits_out;
  logic [12:0] rb;
  int errors = 0;
  int tests_run = 0;
  int cycles = 0;

  always #5 i_sys_clk = ~i_sys_clk;

  phase_setting_control_port phase_setting_control_port_i (
    .i_sys_clk(i_sys_clk), .i_reset(i_reset),
    .i_serial_mode(serial_mode), .i_phase_bits(bits_in),
    .i_accuracy_trim_bit(trim_in), .i_update_strobe(strobe),
    .i_serial_clk(sclk), .i_serial_data(sdata),
    .i_unit_address_pins(unit_pins),
    .o_phase_bits(bits_out), .o_accuracy_trim_bit(trim_out),
    .o_passthrough_out(pass_out), .o_shift_tail_out(tail_out),
    .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata),
    .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .o_reg_rdata(rdata));

  phase_controller phase_controller_i (
    .i_sys_clk(i_sys_clk), .i_shift_tail_out(tail_out),
    .o_serial_mode(serial_mode), .o_phase_bits(bits_in),
    .o_accuracy_trim_bit(trim_in), .o_update_strobe(strobe),
    .o_serial_clk(sclk), .o_serial_data(sdata), .o_readback(rb));

  // ==========================================================
  // compare, register access and verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic check_out(input logic [8:0] exp);
    check({23'h0, trim_out, bits_out}, {23'h0, exp});
  endtask
  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge i_sys_clk);
    reg_wr <= 1'h0;
  endtask
  task automatic reg_check(input logic [3:0] a, input logic [31:0] exp);
    @(posedge i_sys_clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge i_sys_clk);
    reg_rd <= 1'h0;
    #1;
    check(rdata, exp);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // hang guard
  always @(posedge i_sys_clk)
  begin
    cycles++;
    if (cycles == 8000)
    begin
      errors++;
      tally_and_finish();
    end
  end

  // ==========================================================
  // main sequence
  initial
  begin
    unit_pins = 4'h3;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    repeat (5) @(posedge i_sys_clk);
    i_reset <= 1'h0;
    reg_check(4'h0, 32'h1);
    reg_check(4'h4, 32'h0);
    reg_check(4'hc, 32'h0);
    // latched parallel load, trim follows the 90-degree bit
    phase_controller_i.set_lines(9'h0a5); // trim as bit 6
    phase_controller_i.tick(6);
    check_out(9'h000); // held while strobe low
    phase_controller_i.pulse();
    check_out(9'h0a5); // captured on the rise
    // direct mode, each weight then all high
    phase_controller_i.set_strobe(1'h1);
    for (int i = 0; i < 10; i++)
    begin
      phase_controller_i.set_lines(i < 9 ? 9'h1 << i : 9'h1ff);
      phase_controller_i.tick(5);
      check_out(i < 9 ? 9'h1 << i : 9'h1ff); // weights
    end
    phase_controller_i.set_strobe(1'h0);
    // updates disabled by software
    reg_write(4'h0, 32'h0);
    phase_controller_i.set_lines(9'h055);
    phase_controller_i.pulse();
    check_out(9'h1ff);
    reg_write(4'h0, 32'h1);
    // 205.3 degrees to unit 3
    phase_controller_i.set_mode(1'h1);
    phase_controller_i.tick(6);
    phase_controller_i.frame(13'h0692); // state 146
    check_out(9'h092); // matched load
    reg_check(4'h4, 32'h292); // serial mode shown
    reg_check(4'h8, 32'h692); // whole word held
    // passthrough with the clock standing
    phase_controller_i.set_data(1'h0);
    phase_controller_i.tick(5);
    check({31'h0, pass_out}, 32'h0); // follows data
    phase_controller_i.set_data(1'h1);
    phase_controller_i.tick(5);
    check({31'h0, pass_out}, 32'h1); // follows data
    // wrong address leaves the setting alone
    phase_controller_i.frame(13'h1d5a);
    check_out(9'h092); // no change
    check({19'h0, rb}, 32'h349); // tail stream
    reg_check(4'h4, 32'h692);
    reg_write(4'h4, 32'h400);
    reg_check(4'h4, 32'h292);
    // unit pins moved to the held word's address, strobe again
    unit_pins <= 4'he;
    phase_controller_i.tick(4);
    phase_controller_i.pulse();
    check_out(9'h15a); // new unit address matches
    reg_check(4'h4, 32'h35a); // no mismatch flagged
    tally_and_finish();
  end
endmodule
